/* File: core/pse_loopback_regs.sv */
/*
  pse_loopback_regs: loopback and line-config registers of both channels,
  the data routing they steer, per-channel unit-interval phase timing
  and the host-side access to the two pulse-shape tables.
  Assumes a host-port decoder on clk_sys that presents one decoded
  register access per pulse; hostMode is a pin and is synchronised here.
*/
//
// Behaviour
// - Send-all-ones bit forces marks on line, overriding any loopback data.
// - Bit 6 turns the far (remote) loopback on while set.
// - Bit 5 turns near loop A on; it passes the jitter stage if enabled.
// - Host mode with both near loops set drives all ones on receive data.
// - Bit 4 turns near loop B on, through driver, receiver, jitter stage.
// - Loop/config registers readable and writable at 0x16 and 0x17.
// - Bits 3..0 pick line configuration; reset value 1110.
// - Custom shapes only in the four custom modes and in host mode.
// - A mark's shape spans three intervals of 14 phases, 42 entries.
// - A space adds no pulse of its own; tails of the two prior marks still sum in.
// - Interval is 648 ns for DS1 rates and 488 ns for E1; the timer runs 630 ns DS1, 585 ns DSX-1, 480 ns E1.
// - DS1 shapes play all 14 phases of 46.3 ns each; the timer runs each phase 9 cycles, 45 ns.
// - DSX-1 shapes play 13 phases of 49.8 ns, dropping phase 14; the timer runs each phase 9 cycles, 45 ns.
// - E1 shapes play 12 phases of 40.7 ns per interval; the timer runs each phase 8 cycles, 40 ns.
// - Entries hold 7-bit amplitude, bit 7 reads zero, no reset.
// - E1 modes drop the stored phases 13 and 14.
// - Amplitudes are two's complement; 0x3F and 0x40 are full scale.
// - Overlapped sum beyond full scale clamps and flags an overflow.
// - Table access gives register 0x18/0x19, index 0x00..0x29, then data.
`timescale 1ns/1ps
module pse_loopback_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // decoded register access from the host port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] tableIndex,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData_r,
  output logic regRdValid_r,
  // mode pins
  input wire logic hostMode,
  input wire logic jitterEnable,
  // data paths, bit 0 is channel 1
  input wire logic [1:0] txData,
  input wire logic [1:0] lineRxData,
  output logic [1:0] lineTxData_r,
  output logic [1:0] rxDataOut_r,
  // loop steering towards the analog front end
  output logic [1:0] farLoopEnable_r,
  output logic [1:0] nearLoopAJitter_r,
  output logic [1:0] nearLoopBEnable_r,
  output logic [3:0] lineConfigSelectCh1_r,
  output logic [3:0] lineConfigSelectCh2_r,
  // shaped transmit amplitude and overflow pulse
  output logic [6:0] txAmpCh1_r,
  output logic [6:0] txAmpCh2_r,
  output logic [1:0] pulseSumOverflow_r
);

  // shape mode of a line config code, qualified by host mode
  function automatic pse_pkg::pse_shape_e shapeOf(
    input logic [3:0] cfg,
    input logic inHost
  );
    pse_pkg::pse_shape_e s;
    s = pse_pkg::SHAPE_OFF;
    if (inHost) begin
      unique case (cfg)
        pse_pkg::CFG_ARB_E1_COAX: s = pse_pkg::SHAPE_E1;
        pse_pkg::CFG_ARB_E1_PAIR: s = pse_pkg::SHAPE_E1;
        pse_pkg::CFG_ARB_DSX1: s = pse_pkg::SHAPE_DSX1;
        pse_pkg::CFG_ARB_DS1: s = pse_pkg::SHAPE_DS1;
        default: s = pse_pkg::SHAPE_OFF;
      endcase
    end
    return s;
  endfunction : shapeOf

  // last phase index played per interval
  function automatic logic [3:0] lastPhaseOf(input pse_pkg::pse_shape_e s);
    logic [3:0] n;
    n = pse_pkg::PHASES_DS1;
    unique case (s)
      pse_pkg::SHAPE_DSX1: n = pse_pkg::PHASES_DSX1;
      pse_pkg::SHAPE_E1: n = pse_pkg::PHASES_E1;
      pse_pkg::SHAPE_DS1: n = pse_pkg::PHASES_DS1;
      pse_pkg::SHAPE_OFF: n = pse_pkg::PHASES_DS1;
    endcase
    return n - 4'h1;
  endfunction : lastPhaseOf

  // last cycle count of one phase
  function automatic logic [3:0] phaseEndOf(input pse_pkg::pse_shape_e s);
    logic [3:0] c;
    c = pse_pkg::PHASE_DS1_CYC;
    unique case (s)
      pse_pkg::SHAPE_DSX1: c = pse_pkg::PHASE_DSX1_CYC;
      pse_pkg::SHAPE_E1: c = pse_pkg::PHASE_E1_CYC;
      pse_pkg::SHAPE_DS1: c = pse_pkg::PHASE_DS1_CYC;
      pse_pkg::SHAPE_OFF: c = pse_pkg::PHASE_DS1_CYC;
    endcase
    return c - 4'h1;
  endfunction : phaseEndOf

  // host-mode and jitter-enable pin synchronisers
  logic hostModeMeta_r;
  logic hostModeSync_r;
  logic jitterMeta_r;
  logic jitterSync_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hostModeMeta_r <= 1'b0;
      hostModeSync_r <= 1'b0;
      jitterMeta_r <= 1'b0;
      jitterSync_r <= 1'b0;
    end else begin
      hostModeMeta_r <= hostMode;
      hostModeSync_r <= hostModeMeta_r;
      jitterMeta_r <= jitterEnable;
      jitterSync_r <= jitterMeta_r;
    end
  end

  // loop/config registers, index 0 is channel 1
  logic [7:0] loopCfg_r [0:1];

  // access decode
  wire hitLoop1 = regAddr == pse_pkg::ADDR_LOOP_CH1;
  wire hitLoop2 = regAddr == pse_pkg::ADDR_LOOP_CH2;
  wire hitTbl1 = regAddr == pse_pkg::ADDR_TBL_CH1;
  wire hitTbl2 = regAddr == pse_pkg::ADDR_TBL_CH2;
  wire indexOk = tableIndex <= pse_pkg::TBL_LAST_INDEX;
  wire [1:0] loopWr = {regWrite & hitLoop2, regWrite & hitLoop1};
  wire [1:0] tblWr = {regWrite & hitTbl2 & indexOk,
    regWrite & hitTbl1 & indexOk};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loopCfg_r[0] <= pse_pkg::LOOP_CFG_RESET;
      loopCfg_r[1] <= pse_pkg::LOOP_CFG_RESET;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (loopWr[c]) begin
          loopCfg_r[c] <= regWrData;
        end
      end
    end
  end

  // per-channel control fields
  wire [1:0] sendAllOnes = {loopCfg_r[1][pse_pkg::BIT_SEND_ALL_ONES],
    loopCfg_r[0][pse_pkg::BIT_SEND_ALL_ONES]};
  wire [1:0] farLoopEnable = {loopCfg_r[1][pse_pkg::BIT_FAR_LOOP],
    loopCfg_r[0][pse_pkg::BIT_FAR_LOOP]};
  wire [1:0] nearLoopAEnable = {loopCfg_r[1][pse_pkg::BIT_NEAR_LOOP_A],
    loopCfg_r[0][pse_pkg::BIT_NEAR_LOOP_A]};
  wire [1:0] nearLoopBEnable = {loopCfg_r[1][pse_pkg::BIT_NEAR_LOOP_B],
    loopCfg_r[0][pse_pkg::BIT_NEAR_LOOP_B]};
  wire [3:0] lineCfg1 = loopCfg_r[0][pse_pkg::CFG_MSB:pse_pkg::CFG_LSB];
  wire [3:0] lineCfg2 = loopCfg_r[1][pse_pkg::CFG_MSB:pse_pkg::CFG_LSB];

  // transmit and receive routing
  wire [1:0] txFromLoop = (farLoopEnable & lineRxData)
    | (~farLoopEnable & txData);
  wire [1:0] txChosen = sendAllOnes | txFromLoop;
  wire [1:0] rxForceOnes = {2{hostModeSync_r}} & nearLoopAEnable
    & nearLoopBEnable;
  // near loop A returns transmit data; loop B comes back via the receiver
  wire [1:0] rxFromLoop = (nearLoopAEnable & txData)
    | (~nearLoopAEnable & lineRxData);
  wire [1:0] rxChosen = rxForceOnes | rxFromLoop;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lineTxData_r <= 2'h0;
      rxDataOut_r <= 2'h0;
      farLoopEnable_r <= 2'h0;
      nearLoopAJitter_r <= 2'h0;
      nearLoopBEnable_r <= 2'h0;
      lineConfigSelectCh1_r <= pse_pkg::LOOP_CFG_RESET[3:0];
      lineConfigSelectCh2_r <= pse_pkg::LOOP_CFG_RESET[3:0];
    end else begin
      lineTxData_r <= txChosen;
      rxDataOut_r <= rxChosen;
      farLoopEnable_r <= farLoopEnable;
      nearLoopAJitter_r <= nearLoopAEnable & {2{jitterSync_r}};
      nearLoopBEnable_r <= nearLoopBEnable;
      lineConfigSelectCh1_r <= lineCfg1;
      lineConfigSelectCh2_r <= lineCfg2;
    end
  end

  // shape mode per channel
  pse_pkg::pse_shape_e shape [0:1];
  assign shape[0] = shapeOf(lineCfg1, hostModeSync_r);
  assign shape[1] = shapeOf(lineCfg2, hostModeSync_r);

  // unit-interval timers, one per channel
  logic [3:0] phaseCyc_r [0:1];
  logic [3:0] phase_r [0:1];
  logic [1:0] phaseDone;
  logic [1:0] uiDone;

  for (genvar g = 0; g < 2; g++) begin : gTimer
    assign phaseDone[g] = phaseCyc_r[g] >= phaseEndOf(shape[g]);
    // trailing stored phases are never reached, so they are dropped
    assign uiDone[g] = phaseDone[g]
      & (phase_r[g] >= lastPhaseOf(shape[g]));
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < 2; c++) begin
        phaseCyc_r[c] <= 4'h0;
        phase_r[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (shape[c] == pse_pkg::SHAPE_OFF) begin
          phaseCyc_r[c] <= 4'h0;
          phase_r[c] <= 4'h0;
        end else if (uiDone[c]) begin
          phaseCyc_r[c] <= 4'h0;
          phase_r[c] <= 4'h0;
        end else if (phaseDone[c]) begin
          phaseCyc_r[c] <= 4'h0;
          phase_r[c] <= phase_r[c] + 4'h1;
        end else begin
          phaseCyc_r[c] <= phaseCyc_r[c] + 4'h1;
        end
      end
    end
  end

  // channel shapers
  pse_shape_if chIf [0:1] ();

  for (genvar g = 0; g < 2; g++) begin : gShaper
    assign chIf[g].wrEn = tblWr[g];
    assign chIf[g].wrIdx = tableIndex[5:0];
    assign chIf[g].wrData = regWrData[6:0];
    assign chIf[g].rdIdx = indexOk ? tableIndex[5:0] : 6'h00;
    assign chIf[g].uiStart = uiDone[g];
    assign chIf[g].phase = phase_r[g];
    assign chIf[g].mark = txChosen[g];
    assign chIf[g].arbEn = shape[g] != pse_pkg::SHAPE_OFF;

    pse_pulse_shaper uShaper (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .chan(chIf[g])
    );
  end

  wire [6:0] tblRd1 = chIf[0].rdData;
  wire [6:0] tblRd2 = chIf[1].rdData;
  wire [6:0] amp1 = chIf[0].amp;
  wire [6:0] amp2 = chIf[1].amp;
  wire [1:0] ovf = {chIf[1].ovf, chIf[0].ovf};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txAmpCh1_r <= 7'h00;
      txAmpCh2_r <= 7'h00;
      pulseSumOverflow_r <= 2'h0;
    end else begin
      txAmpCh1_r <= amp1;
      txAmpCh2_r <= amp2;
      pulseSumOverflow_r <= ovf;
    end
  end

  // read-back, unmapped addresses and bad indexes read zero
  wire [7:0] rdMux = hitLoop1 ? loopCfg_r[0]
    : hitLoop2 ? loopCfg_r[1]
    : (hitTbl1 && indexOk) ? {1'b0, tblRd1}
    : (hitTbl2 && indexOk) ? {1'b0, tblRd2}
    : 8'h00;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdData_r <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRead;
      if (regRead) begin
        regRdData_r <= rdMux;
      end
    end
  end

endmodule : pse_loopback_regs

/* File: inc/pse_pkg.sv */
/*
  pse_pkg: shared constants for the loopback/line-config registers and
  the per-channel pulse-shape tables of the dual line interface.
  Assumes a 200 MHz system clock feeding every block that uses it.
*/
package pse_pkg;

  // register addresses as carried in the address command byte
  localparam logic [7:0] ADDR_LOOP_CH1 = 8'h16;
  localparam logic [7:0] ADDR_LOOP_CH2 = 8'h17;
  localparam logic [7:0] ADDR_TBL_CH1 = 8'h18;
  localparam logic [7:0] ADDR_TBL_CH2 = 8'h19;

  // loopback / line config field positions
  localparam int BIT_SEND_ALL_ONES = 7;
  localparam int BIT_FAR_LOOP = 6;
  localparam int BIT_NEAR_LOOP_A = 5;
  localparam int BIT_NEAR_LOOP_B = 4;
  localparam int CFG_MSB = 3;
  localparam int CFG_LSB = 0;
  localparam logic [7:0] LOOP_CFG_RESET = 8'h0E;

  // line config codes of the four custom-shape modes
  localparam logic [3:0] CFG_ARB_E1_COAX = 4'h8;
  localparam logic [3:0] CFG_ARB_E1_PAIR = 4'h9;
  localparam logic [3:0] CFG_ARB_DSX1 = 4'hA;
  localparam logic [3:0] CFG_ARB_DS1 = 4'hB;

  // shape table geometry
  localparam int PHASES_PER_UI = 14;
  localparam int UI_SPAN = 3;
  localparam int TBL_DEPTH = 42;
  localparam logic [7:0] TBL_LAST_INDEX = 8'h29;
  localparam int AMP_W = 7;
  localparam logic [6:0] AMP_FULL_POS = 7'h3F;
  localparam logic [6:0] AMP_FULL_NEG = 7'h40;

  // phases actually played per unit interval
  localparam logic [3:0] PHASES_DS1 = 4'hE;
  localparam logic [3:0] PHASES_DSX1 = 4'hD;
  localparam logic [3:0] PHASES_E1 = 4'hC;

  // timing: unit intervals and phase lengths in their own units
  localparam int CLK_PERIOD_PS = 5000;
  localparam int UI_DS1_NS = 648;
  localparam int UI_E1_NS = 488;
  localparam int PHASE_DS1_PS = 46300;
  localparam int PHASE_DSX1_PS = 49800;
  localparam int PHASE_E1_PS = 40700;
  // longest-fit phase lengths in clock cycles, rounded down
  localparam logic [3:0] PHASE_DS1_CYC = 4'(PHASE_DS1_PS / CLK_PERIOD_PS);
  localparam logic [3:0] PHASE_DSX1_CYC =
    4'(PHASE_DSX1_PS / CLK_PERIOD_PS);
  localparam logic [3:0] PHASE_E1_CYC = 4'(PHASE_E1_PS / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    SHAPE_OFF,
    SHAPE_DS1,
    SHAPE_DSX1,
    SHAPE_E1
  } pse_shape_e;

endpackage : pse_pkg

/* File: inc/pse_shape_if.sv */
/*
  pse_shape_if: carries one channel's table port and phase timing
  between the register top and its pulse shaper.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface pse_shape_if;
  logic wrEn;
  logic [5:0] wrIdx;
  logic [6:0] wrData;
  logic [5:0] rdIdx;
  logic [6:0] rdData;
  logic uiStart;
  logic [3:0] phase;
  logic mark;
  logic arbEn;
  logic [6:0] amp;
  logic ovf;

  modport top (
    output wrEn, wrIdx, wrData, rdIdx, uiStart, phase, mark, arbEn,
    input rdData, amp, ovf
  );
  modport shaper (
    input wrEn, wrIdx, wrData, rdIdx, uiStart, phase, mark, arbEn,
    output rdData, amp, ovf
  );
endinterface : pse_shape_if

/* File: core/pse_pulse_shaper.sv */
/*
  pse_pulse_shaper: one channel's 42-entry shape table and the summing
  of the three overlapping mark shapes into one clamped amplitude.
  Assumes phase and uiStart come from the top's unit-interval timer.
*/
`timescale 1ns/1ps
module pse_pulse_shaper (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // channel link to the top
  pse_shape_if.shaper chan
);

  // table contents carry no reset
  logic [6:0] table_r [0:pse_pkg::TBL_DEPTH-1];
  logic [2:0] markHist_r;
  logic [6:0] amp_r;
  logic ovf_r;

  function automatic logic signed [8:0] tapAt(
    input logic [6:0] entry,
    input logic live
  );
    return live ? 9'(signed'(entry)) : 9'sh000;
  endfunction : tapAt

  wire [5:0] idxUi1 = 6'(chan.phase);
  wire [5:0] idxUi2 = 6'(chan.phase) + 6'(pse_pkg::PHASES_PER_UI);
  wire [5:0] idxUi3 = 6'(chan.phase) + 6'(2 * pse_pkg::PHASES_PER_UI);
  // spaces contribute nothing, but a zero still carries the tails of the two prior marks
  wire signed [8:0] tapSum = tapAt(table_r[idxUi1], markHist_r[0])
    + tapAt(table_r[idxUi2], markHist_r[1])
    + tapAt(table_r[idxUi3], markHist_r[2]);
  wire sumHigh = tapSum > 9'sh03F;
  wire sumLow = tapSum < -9'sh040;
  wire [6:0] clamped = sumHigh ? pse_pkg::AMP_FULL_POS
    : sumLow ? pse_pkg::AMP_FULL_NEG : tapSum[6:0];

  assign chan.rdData = table_r[chan.rdIdx];
  assign chan.amp = amp_r;
  assign chan.ovf = ovf_r;

  always_ff @(posedge clk_sys) begin
    if (chan.wrEn) begin
      table_r[chan.wrIdx] <= chan.wrData;
    end
  end

  // newest mark in bit 0, shapes span three intervals
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      markHist_r <= 3'h0;
    end else if (chan.uiStart) begin
      markHist_r <= {markHist_r[1:0], chan.mark};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      amp_r <= 7'h00;
      ovf_r <= 1'b0;
    end else begin
      amp_r <= chan.arbEn ? clamped : 7'h00;
      ovf_r <= chan.arbEn & (sumHigh | sumLow);
    end
  end

endmodule : pse_pulse_shaper

/* File: dv/pse_host_model.sv */
/*
  pse_host_model: host side of the decoded register access port.
  Assumes the bench calls its tasks from one process on clk_sys.
*/
`timescale 1ns/1ps
module pse_host_model (
  // clock
  input wire logic clk_sys,
  // requests
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] tableIndex,
  output logic [7:0] regWrData,
  // answers
  input wire logic [7:0] regRdData_r,
  input wire logic regRdValid_r
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    tableIndex = 8'h00;
    regWrData = 8'h00;
  end

  // address, index and data travel together in one pulse
  task automatic wr(input logic [7:0] a, i, d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    tableIndex <= i;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, i, output logic [7:0] d,
                    output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    tableIndex <= i;
    @(posedge clk_sys);
    regRead <= 1'b0;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(posedge clk_sys);
      if (regRdValid_r === 1'b1) begin
        ok = 1'b1;
        d = regRdData_r;
      end
    end
  endtask : rd
endmodule : pse_host_model

/* File: dv/pse_loopback_regs_asserts.sv */
/*
  pse_loopback_regs_asserts: port timing checks of the register top.
  Assumes one clk_sys domain and resetn low-active.
*/
`timescale 1ns/1ps
module pse_loopback_regs_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register access
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData_r,
  input wire logic regRdValid_r,
  // routing
  input wire logic hostMode,
  input wire logic [1:0] txData,
  input wire logic [1:0] lineRxData,
  input wire logic [1:0] lineTxData_r,
  input wire logic [1:0] rxDataOut_r,
  input wire logic [1:0] farLoopEnable_r,
  input wire logic [1:0] nearLoopAJitter_r,
  input wire logic [1:0] nearLoopBEnable_r,
  input wire logic [3:0] lineConfigSelectCh1_r,
  // shaping
  input wire logic [6:0] txAmpCh1_r,
  input wire logic [6:0] txAmpCh2_r,
  input wire logic [1:0] pulseSumOverflow_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence hostSettled;
    hostMode [*3];
  endsequence
  sequence bothNearLoops;
    (nearLoopAJitter_r[0] && nearLoopBEnable_r[0] && !regWrite) [*3];
  endsequence

  read_answer_a: assert property (regRead |=> regRdValid_r)
    else $error("read not answered in one cycle");
  answer_cause_a: assert property (regRdValid_r |-> $past(regRead))
    else $error("read answer without a read");
  // register then output flop: fields show two edges after the write
  cfg_write_a: assert property (regWrite && regAddr == 8'h16 |=>
    ##1 {4'h0, lineConfigSelectCh1_r} == ($past(regWrData, 2) & 8'h0F))
    else $error("line config not taken from write");
  far_write_a: assert property (regWrite && regAddr == 8'h17 |=>
    ##1 {1'b0, farLoopEnable_r[1], 6'h00} == ($past(regWrData, 2) & 8'h40))
    else $error("far loop bit not taken from write");
  read_back_a: assert property (regRead && regAddr == 8'h16 |=>
    regRdData_r[3:0] == $past(lineConfigSelectCh1_r))
    else $error("read data differs from register");
  // farLoopEnable_r now holds the bit that steered the last line sample
  tx_route_a: assert property ($past(resetn) |-> (~lineTxData_r &
    ((farLoopEnable_r & $past(lineRxData)) |
    (~farLoopEnable_r & $past(txData)))) == 2'b00)
    else $error("routed one lost on line output");
  both_near_a: assert property (hostSettled ##0 bothNearLoops |=>
    rxDataOut_r[0])
    else $error("receive not all ones with both near loops");
  amp_idle_a: assert property ((!hostMode) [*7] |->
    txAmpCh1_r == 7'h00 && txAmpCh2_r == 7'h00)
    else $error("shaped output outside host mode");
  clamp_full_a: assert property (pulseSumOverflow_r[1] |->
    txAmpCh2_r == 7'h3F || txAmpCh2_r == 7'h40)
    else $error("overflow without full-scale output");
endmodule : pse_loopback_regs_asserts

bind pse_loopback_regs pse_loopback_regs_asserts
  pse_loopback_regs_asserts_inst (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .regWrite(regWrite),
  .regRead(regRead),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData_r(regRdData_r),
  .regRdValid_r(regRdValid_r),
  .hostMode(hostMode),
  .txData(txData),
  .lineRxData(lineRxData),
  .lineTxData_r(lineTxData_r),
  .rxDataOut_r(rxDataOut_r),
  .farLoopEnable_r(farLoopEnable_r),
  .nearLoopAJitter_r(nearLoopAJitter_r),
  .nearLoopBEnable_r(nearLoopBEnable_r),
  .lineConfigSelectCh1_r(lineConfigSelectCh1_r),
  .txAmpCh1_r(txAmpCh1_r),
  .txAmpCh2_r(txAmpCh2_r),
  .pulseSumOverflow_r(pulseSumOverflow_r)
);

/* File: dv/test_pse_loopback_regs.sv */
/*
  test_pse_loopback_regs: self-checking bench of the register top.
  Assumes the host model speaks the decoded one-pulse access port.
*/
`timescale 1ns/1ps
module test_pse_loopback_regs;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hostMode = 1'b0;
  logic jitterEnable = 1'b1;
  logic [1:0] txData = 2'b00;
  logic [1:0] lineRxData = 2'b00;
  logic regWrite, regRead, regRdValid_r;
  logic [7:0] regAddr, tableIndex, regWrData, regRdData_r;
  logic [1:0] lineTx, rxOut, farEn, nearA, nearB, ovf;
  logic [3:0] cfg1, cfg2;
  logic [6:0] amp1, amp2;
  logic [31:0] seed = 32'hE812;
  logic [7:0] regs [2];
  int tbl [2][42];
  logic [3:0] modes [4] = '{4'hB, 4'hA, 4'h9, 4'h8};
  int nPh [4] = '{14, 13, 12, 12};
  int phPs [4] = '{pse_pkg::PHASE_DS1_PS, pse_pkg::PHASE_DSX1_PS,
                   pse_pkg::PHASE_E1_PS, pse_pkg::PHASE_E1_PS};
  int error_cnt = 0;
  int n_compared = 0;
  int steps, w;
  bit seenFull, seenOvf, seenOvfA;

  always #2.5 clk_sys = ~clk_sys;

  pse_host_model pse_host_model_inst (
    .clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .tableIndex(tableIndex), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r)
  );
  pse_loopback_regs pse_loopback_regs_inst (
    .clk_sys(clk_sys), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .tableIndex(tableIndex),
    .regWrData(regWrData), .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r), .hostMode(hostMode),
    .jitterEnable(jitterEnable), .txData(txData),
    .lineRxData(lineRxData), .lineTxData_r(lineTx), .rxDataOut_r(rxOut),
    .farLoopEnable_r(farEn), .nearLoopAJitter_r(nearA),
    .nearLoopBEnable_r(nearB), .lineConfigSelectCh1_r(cfg1),
    .lineConfigSelectCh2_r(cfg2), .txAmpCh1_r(amp1), .txAmpCh2_r(amp2),
    .pulseSumOverflow_r(ovf)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input int i, input logic [7:0] d);
    pse_host_model_inst.wr(a, 8'(i), d);
    if (a[7:1] == 7'h0B) regs[a[0]] = d;
    if (a[7:1] == 7'h0C && i < 42) tbl[a[0]][i] = int'(d & 8'h7F);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int i, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    pse_host_model_inst.rd(a, 8'(i), d, ok);
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: no read answer", $time);
      close_out();
    end
    check(d, e);
  endtask : rd

  // random line data against the routing model
  task automatic pathCheck();
    logic [1:0] t, r, eTx, eRx;
    repeat (6) begin
      {t, r} = 4'(rnd());
      @(posedge clk_sys);
      txData <= t;
      lineRxData <= r;
      @(posedge clk_sys);
      #1;
      for (int c = 0; c < 2; c++) begin
        eTx[c] = regs[c][7] | (regs[c][6] ? r[c] : t[c]);
        eRx[c] = (hostMode & regs[c][5] & regs[c][4]) |
                 (regs[c][5] ? t[c] : r[c]);
      end
      check({4'h0, lineTx, rxOut}, {4'h0, eTx, eRx});
    end
  endtask : pathCheck

  task automatic waitAmp(input bit want);
    for (steps = 0; (amp1 === 7'h01) != want; steps++) begin
      if (steps == 600) begin
        error_cnt++;
        $display("unexpected at %0t: shape stalled", $time);
        close_out();
      end
      @(posedge clk_sys);
      #1;
      seenFull |= (amp1 === pse_pkg::AMP_FULL_POS);
      seenOvf |= (ovf[1] === 1'b1);
      seenOvfA |= (ovf[0] !== 1'b0);
    end
  endtask : waitAmp

  initial begin
    regs = '{8'h0E, 8'h0E};
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    check({cfg2, cfg1}, 8'hEE);
    rd(pse_pkg::ADDR_LOOP_CH1, 0, 8'h0E);
    rd(pse_pkg::ADDR_LOOP_CH2, 0, 8'h0E);
    rd(8'h15, 0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      logic [15:0] v;
      v = 16'(rnd()) & 16'hFFF7;
      wr(pse_pkg::ADDR_LOOP_CH1, 0, i[0] ? v[7:0] | 8'h30 : v[7:0]);
      wr(pse_pkg::ADDR_LOOP_CH2, 0, {v[15:12], v[3:0]});
      if (i == 4) hostMode <= 1'b1;
      rd(pse_pkg::ADDR_LOOP_CH1, 0, regs[0]);
      rd(pse_pkg::ADDR_LOOP_CH2, 0, regs[1]);
      check({farEn, nearA, nearB, 2'b00}, {regs[1][6], regs[0][6],
        regs[1][5], regs[0][5], regs[1][4], regs[0][4], 2'b00});
      check({cfg2, cfg1}, {regs[1][3:0], regs[0][3:0]});
      pathCheck();
    end
    @(posedge clk_sys);
    jitterEnable <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({6'h0, nearA}, 8'h00);
    for (int i = 0; i < 42; i++) begin
      wr(pse_pkg::ADDR_TBL_CH1, i, i == 0 ? 8'h81 : 8'(i == 13) * 8'h3F);
      wr(pse_pkg::ADDR_TBL_CH2, i, 8'h3F | 8'(rnd() & 32'h80));
    end
    for (int i = 0; i < 43; i++) begin
      rd(pse_pkg::ADDR_TBL_CH1, i, i < 42 ? 8'(tbl[0][i]) : 8'h00);
      rd(pse_pkg::ADDR_TBL_CH2, i, i < 42 ? 8'(tbl[1][i]) : 8'h00);
    end
    @(posedge clk_sys);
    txData <= 2'b11;
    for (int m = 0; m < 4; m++) begin
      wr(pse_pkg::ADDR_LOOP_CH1, 0, 8'h0E);
      wr(pse_pkg::ADDR_LOOP_CH2, 0, 8'h0E);
      wr(pse_pkg::ADDR_LOOP_CH1, 0, {4'h0, modes[m]});
      wr(pse_pkg::ADDR_LOOP_CH2, 0, {4'h0, modes[m]});
      waitAmp(1'b1);
      waitAmp(1'b0);
      waitAmp(1'b1);
      seenFull = 1'b0;
      seenOvf = 1'b0;
      seenOvfA = 1'b0;
      waitAmp(1'b0);
      w = steps;
      check(8'(w), 8'(phPs[m] / pse_pkg::CLK_PERIOD_PS));
      waitAmp(1'b1);
      check(8'(w + steps), 8'(nPh[m] * w));
      check({5'h0, seenFull, seenOvf, seenOvfA},
        {5'h0, m == 0, 1'b1, 1'b0});
      check({1'b0, amp2}, 8'h3F);
    end
    @(posedge clk_sys);
    hostMode <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check({1'b0, amp1}, 8'h00);
    hostMode <= 1'b1;
    txData <= 2'b00;
    repeat (400) @(posedge clk_sys);
    #1;
    check({1'b0, amp1 | amp2}, 8'h00);
    close_out();
  end
endmodule : test_pse_loopback_regs
